// ---- src/rssc_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
module rssc_regs
#(
  parameter int NPHASE = 2,
  parameter int LOAD_W = 8,
  parameter int CUR_W = 8
)
(
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clkEn,
  // Command register port
  input wire logic [7:0] regPage,
  input wire logic [7:0] regCode,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [15:0] regWdata,
  output logic [15:0] regRdata,
  output logic regAck,
  output logic regErr,
  // Phase shedding
  input wire logic [LOAD_W-1:0] loadCurrent,
  output rssc_pkg::rssc_shed_type shedState,
  // Reference stepping
  input wire logic railEnable,
  input wire logic bootDone,
  input wire logic decayMode,
  input wire logic stepReq,
  output logic refStep,
  output logic bootActive,
  // Per-phase valley limit
  input wire logic swCycle,
  input wire logic [rssc_pkg::RSSC_OFFSET_W-1:0] phaseLimitCode,
  input wire logic [NPHASE-1:0][CUR_W-1:0] phaseCurrent,
  output logic [NPHASE-1:0] valleyHit
);
  import rssc_pkg::*;

  // ****************************************************************
  // Register file
  // ****************************************************************
  logic [15:0] shed_r, shed_nxt; // Shedding thresholds
  logic [15:0] decay_r, decay_nxt; // Decay hold
  logic [15:0] offset_r, offset_nxt; // Limit offset
  logic [15:0] slew_r, slew_nxt; // Boot slew count as written
  logic [RSSC_SLEW_W-1:0] slewEff_r, slewEff_nxt; // Count in force
  logic [15:0] rdata_r, rdata_nxt;
  logic ack_r, ack_nxt;
  logic err_r, err_nxt;
  logic pageHit; // Access aimed at rail two
  logic [15:0] wMask; // Writable bits of addressed register
  logic [15:0] rSel; // Content of addressed register
  logic known; // Code is one of ours

  // Decode and next register values
  always_comb
  begin
    pageHit = (regPage == RSSC_PAGE_RAIL2);
    known = 1'b1;
    wMask = 16'h0000;
    rSel = 16'h0000;
    case (regCode)
      RSSC_CMD_SHED: {wMask, rSel} = {RSSC_MASK_SHED, shed_r}; // Thresholds word
      RSSC_CMD_DECAY: {wMask, rSel} = {RSSC_MASK_DECAY, decay_r}; // Decay byte
      RSSC_CMD_OFFSET: {wMask, rSel} = {RSSC_MASK_OFFSET, offset_r}; // Offset byte
      RSSC_CMD_SLEW: {wMask, rSel} = {RSSC_MASK_SLEW, slew_r}; // Slew word
      default: known = 1'b0; // Not ours: refused
    endcase
    shed_nxt = shed_r;
    decay_nxt = decay_r;
    offset_nxt = offset_r;
    slew_nxt = slew_r;
    slewEff_nxt = slewEff_r;
    rdata_nxt = rdata_r;
    ack_nxt = 1'b0;
    err_nxt = 1'b0;
    if (regWrite || regRead)
    begin
      ack_nxt = pageHit && known;
      err_nxt = !(pageHit && known); // Unmapped answers with error, no data
      rdata_nxt = 16'h0000;
      if (regRead && pageHit)
        rdata_nxt = rSel & wMask; // Reserved bits read zero
    end
    if (regWrite && pageHit)
    begin
      // Only writable bits are stored
      case (regCode)
        RSSC_CMD_SHED: shed_nxt = regWdata & RSSC_MASK_SHED;
        RSSC_CMD_DECAY: decay_nxt = regWdata & RSSC_MASK_DECAY;
        RSSC_CMD_OFFSET: offset_nxt = regWdata & RSSC_MASK_OFFSET;
        RSSC_CMD_SLEW:
        begin
          slew_nxt = regWdata & RSSC_MASK_SLEW;
          // A count ending in five ones is ineffective: old count stays
          if (regWdata[RSSC_SLEW_BAD_W-1:0] != {RSSC_SLEW_BAD_W{1'b1}})
            slewEff_nxt = regWdata[RSSC_SLEW_W-1:0];
        end
        default: ;
      endcase
    end
  end

  // Register storage
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      shed_r <= RSSC_RST_SHED;
      decay_r <= RSSC_RST_DECAY;
      offset_r <= RSSC_RST_OFFSET;
      slew_r <= RSSC_RST_SLEW;
      slewEff_r <= RSSC_RST_SLEW[RSSC_SLEW_W-1:0];
      rdata_r <= 16'h0000;
      ack_r <= 1'b0;
      err_r <= 1'b0;
    end
    else if (clkEn)
    begin
      shed_r <= shed_nxt;
      decay_r <= decay_nxt;
      offset_r <= offset_nxt;
      slew_r <= slew_nxt;
      slewEff_r <= slewEff_nxt;
      rdata_r <= rdata_nxt;
      ack_r <= ack_nxt;
      err_r <= err_nxt;
    end
  end

  assign regRdata = rdata_r;
  assign regAck = ack_r;
  assign regErr = err_r;

  // ****************************************************************
  // Phase shedding
  // ****************************************************************
  rssc_shed_type shed_st_r, shed_st_nxt;
  logic [6:0] hys; // Margin in half-amp counts
  logic [6:0] singleTh; // Two-to-one threshold
  logic [6:0] dcmTh; // One-phase to DCM threshold
  logic [LOAD_W:0] load; // Load widened for compare

  // Hysteresis keeps the rail from chattering at a threshold
  always_comb
  begin
    hys = 7'(shed_r[RSSC_HYS_LSB +: RSSC_HYS_W]);
    singleTh = 7'(shed_r[RSSC_SINGLE_LSB +: RSSC_SINGLE_W]);
    dcmTh = 7'(shed_r[RSSC_DCM_LSB +: RSSC_DCM_W]);
    load = {1'b0, loadCurrent};
    shed_st_nxt = shed_st_r;
    case (shed_st_r)
      RSSC_TWO_CCM:
        if (load < (LOAD_W+1)'(singleTh))
          shed_st_nxt = RSSC_ONE_CCM;
      RSSC_ONE_CCM:
        if (load > (LOAD_W+1)'(singleTh + hys))
          shed_st_nxt = RSSC_TWO_CCM;
        else if (load < (LOAD_W+1)'(dcmTh))
          shed_st_nxt = RSSC_ONE_DCM;
      RSSC_ONE_DCM:
        if (load > (LOAD_W+1)'(singleTh + hys))
          shed_st_nxt = RSSC_TWO_CCM; // Large step skips one-phase CCM
        else if (load > (LOAD_W+1)'(dcmTh + hys))
          shed_st_nxt = RSSC_ONE_CCM;
      default:
        shed_st_nxt = RSSC_TWO_CCM;
    endcase
  end

  // Shedding state register
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      shed_st_r <= RSSC_TWO_CCM;
    else if (clkEn)
      shed_st_r <= shed_st_nxt;
  end

  assign shedState = shed_st_r;

  // ****************************************************************
  // Reference step pacing
  // ****************************************************************
  logic [15:0] timer_r, timer_nxt; // Cycles left before next step
  logic boot_r, boot_nxt;
  logic step_r, step_nxt;
  logic railEn_r, railEn_nxt; // For turn-on edge
  logic [15:0] bootHold; // Cycles per boot step
  logic [15:0] decayHold; // Least cycles per decay step

  // Boot pacing is autonomous; decay pacing gates requested steps
  always_comb
  begin
    bootHold = (16'(slewEff_r) + 16'(RSSC_BOOT_EXTRA)) * 16'(RSSC_BOOT_LSB_CYC);
    decayHold = 16'(decay_r[RSSC_DECAY_W-1:0]) * 16'(RSSC_DECAY_LSB_CYC);
    if (decayHold == 16'h0000)
      decayHold = 16'h0001;
    railEn_nxt = railEnable;
    boot_nxt = boot_r;
    timer_nxt = (timer_r != 16'h0000) ? timer_r - 16'h0001 : timer_r;
    step_nxt = 1'b0;
    if (!railEnable || bootDone)
      boot_nxt = 1'b0;
    if (railEnable && !railEn_r)
    begin
      // Only the turn-on ramp uses the boot step time
      boot_nxt = 1'b1;
      timer_nxt = bootHold - 16'h0001;
    end
    else if (boot_r && !bootDone && railEnable)
    begin
      if (timer_r == 16'h0000)
      begin
        step_nxt = 1'b1;
        timer_nxt = bootHold - 16'h0001;
      end
    end
    else if (decayMode)
    begin
      if (stepReq && timer_r == 16'h0000)
      begin
        step_nxt = 1'b1;
        timer_nxt = decayHold - 16'h0001;
      end
    end
    else
      step_nxt = stepReq; // Normal slew is paced elsewhere
  end

  // Pacing registers
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      timer_r <= 16'h0000;
      boot_r <= 1'b0;
      step_r <= 1'b0;
      railEn_r <= 1'b0;
    end
    else if (clkEn)
    begin
      timer_r <= timer_nxt;
      boot_r <= boot_nxt;
      step_r <= step_nxt;
      railEn_r <= railEn_nxt;
    end
  end

  assign refStep = step_r;
  assign bootActive = boot_r;

  // ****************************************************************
  // Per-phase valley limit
  // ****************************************************************
  logic [CUR_W:0] limitRef; // Internal reference from code and offset

  // Offset converts the programmed limit into the reference
  assign limitRef = (CUR_W+1)'(phaseLimitCode) + (CUR_W+1)'(offset_r[RSSC_OFFSET_W-1:0]);

  generate
    for (genvar p = 0; p < NPHASE; p++)
    begin : gPhase
      logic hit_r, hit_nxt;
      // Compare once per switching cycle, hold between
      always_comb
      begin
        hit_nxt = hit_r;
        if (swCycle)
          hit_nxt = ({1'b0, phaseCurrent[p]} > limitRef);
      end
      always_ff @(posedge mclk)
      begin
        if (!rst_n)
          hit_r <= 1'b0;
        else if (clkEn)
          hit_r <= hit_nxt;
      end
      assign valleyHit[p] = hit_r;
    end
  endgenerate

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_unmapped_err: assert property (@(posedge mclk) disable iff (!rst_n)
    (clkEn && regRead && regPage != RSSC_PAGE_RAIL2) |=> (regErr && !regAck))
    else $error("off-page access not refused");
  chk_reserved_zero: assert property (@(posedge mclk) disable iff (!rst_n)
    (clkEn && regRead && regPage == RSSC_PAGE_RAIL2 && regCode == RSSC_CMD_SLEW)
    |=> (regRdata[15:11] == 5'h00 && regAck))
    else $error("reserved slew bits read nonzero");
  chk_write_readback: assert property (@(posedge mclk) disable iff (!rst_n)
    (clkEn && regWrite && regPage == RSSC_PAGE_RAIL2 && regCode == RSSC_CMD_DECAY)
    |=> (decay_r == ($past(regWdata) & RSSC_MASK_DECAY)))
    else $error("decay register write mismatch");
  chk_shed_down: assert property (@(posedge mclk) disable iff (!rst_n)
    (clkEn && shedState == RSSC_TWO_CCM && load < (LOAD_W+1)'(singleTh))
    |=> shedState == RSSC_ONE_CCM)
    else $error("two-phase not shed below threshold");
  chk_shed_dcm: assert property (@(posedge mclk) disable iff (!rst_n)
    (clkEn && shedState == RSSC_ONE_CCM && load <= (LOAD_W+1)'(singleTh + hys)
      && load < (LOAD_W+1)'(dcmTh)) |=> shedState == RSSC_ONE_DCM)
    else $error("DCM not entered below threshold");
  chk_hys_margin: assert property (@(posedge mclk) disable iff (!rst_n)
    (clkEn && shedState == RSSC_ONE_CCM && load <= (LOAD_W+1)'(singleTh + hys))
    |=> shedState != RSSC_TWO_CCM)
    else $error("phase re-added inside hysteresis band");
  chk_boot_space: assert property (@(posedge mclk) disable iff (!rst_n)
    (refStep && bootActive && clkEn) |-> (timer_r == bootHold - 16'h0001))
    else $error("boot step spacing wrong");
  chk_decay_gap: assert property (@(posedge mclk) disable iff (!rst_n)
    (clkEn && step_nxt && decayMode && !boot_r && !(railEnable && !railEn_r))
    |-> timer_r == 16'h0000)
    else $error("decay step issued before hold elapsed");
  chk_boot_only_on: assert property (@(posedge mclk) disable iff (!rst_n)
    (clkEn && !railEnable) |=> !bootActive)
    else $error("boot pacing outside turn-on");
  chk_valley_cmp: assert property (@(posedge mclk) disable iff (!rst_n)
    (clkEn && swCycle) |=> (valleyHit[0] == ($past(phaseCurrent[0]) > $past(limitRef))))
    else $error("valley compare wrong");
endmodule
`default_nettype wire

// ---- common/rssc_pkg.sv ----
// ****************************************************************
// Register map and timing constants
// ****************************************************************
package rssc_pkg;

  // Page and command codes of the second rail
  localparam logic [7:0] RSSC_PAGE_RAIL2 = 8'h01;
  localparam logic [7:0] RSSC_CMD_SHED = 8'hC7;
  localparam logic [7:0] RSSC_CMD_DECAY = 8'hC9;
  localparam logic [7:0] RSSC_CMD_OFFSET = 8'hCA;
  localparam logic [7:0] RSSC_CMD_SLEW = 8'hCB;

  // Writable-bit masks, reserved bits cleared
  localparam logic [15:0] RSSC_MASK_SHED = 16'h3FFF;
  localparam logic [15:0] RSSC_MASK_DECAY = 16'h0003;
  localparam logic [15:0] RSSC_MASK_OFFSET = 16'h007F;
  localparam logic [15:0] RSSC_MASK_SLEW = 16'h07FF;

  // Field positions and widths
  localparam int RSSC_HYS_LSB = 10;
  localparam int RSSC_HYS_W = 4;
  localparam int RSSC_SINGLE_LSB = 4;
  localparam int RSSC_SINGLE_W = 6;
  localparam int RSSC_DCM_LSB = 0;
  localparam int RSSC_DCM_W = 4;
  localparam int RSSC_DECAY_W = 2;
  localparam int RSSC_OFFSET_W = 7;
  localparam int RSSC_SLEW_W = 11;
  localparam int RSSC_SLEW_BAD_W = 5;

  // Reset values
  localparam logic [15:0] RSSC_RST_SHED = 16'h0000;
  localparam logic [15:0] RSSC_RST_DECAY = 16'h0000;
  localparam logic [15:0] RSSC_RST_OFFSET = 16'h0000;
  localparam logic [15:0] RSSC_RST_SLEW = 16'h0000;

  // Timing: times in ps, cycle counts derived (least times round up)
  localparam int RSSC_CLK_PERIOD_PS = 5000;
  localparam int RSSC_DECAY_LSB_PS = 100000;
  localparam int RSSC_BOOT_LSB_PS = 50000;
  localparam int RSSC_BOOT_EXTRA = 3;
  localparam int RSSC_DECAY_LSB_CYC =
    (RSSC_DECAY_LSB_PS + RSSC_CLK_PERIOD_PS - 1) / RSSC_CLK_PERIOD_PS;
  localparam int RSSC_BOOT_LSB_CYC =
    (RSSC_BOOT_LSB_PS + RSSC_CLK_PERIOD_PS - 1) / RSSC_CLK_PERIOD_PS;

  // Operating states of the phase shedding logic
  typedef enum logic [1:0] {RSSC_TWO_CCM, RSSC_ONE_CCM, RSSC_ONE_DCM} rssc_shed_type;

endpackage

// ---- testbench/rssc_host.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****
// Host side of the command port
// ****
module rssc_host
#(
  parameter int GAIN = 1000
)
(
  // Clock
  input wire logic mclk,
  // Request
  output logic [7:0] regPage,
  output logic [7:0] regCode,
  output logic regWrite,
  output logic regRead,
  output logic [15:0] regWdata,
  // Answer
  input wire logic [15:0] regRdata,
  input wire logic regAck,
  input wire logic regErr
);
  // Offset derived from the gain register value
  localparam logic [15:0] OFFSET_VAL = 16'(10086 / GAIN);
  // Idle bus at time zero
  initial
  begin
    regPage = 8'h00;
    regCode = 8'h00;
    regWrite = 1'b0;
    regRead = 1'b0;
    regWdata = 16'h0000;
  end
  // One-cycle request pulse, answer one cycle later
  task automatic access(input logic [7:0] page, input logic [7:0] code,
    input logic wr, input logic [15:0] wd, output logic [15:0] rd,
    output logic [1:0] rsp);
    int n;
    n = 0;
    @(negedge mclk);
    regPage = page;
    regCode = code;
    regWrite = wr;
    regRead = !wr;
    regWdata = wd;
    @(negedge mclk);
    regWrite = 1'b0;
    regRead = 1'b0;
    // Released data shows a changed value, not the old one
    regWdata = ~wd;
    while (!(regAck || regErr) && n < 4)
    begin
      @(negedge mclk);
      n++;
    end
    rd = regRdata;
    rsp = {regAck, regErr};
  endtask
endmodule
`default_nettype wire

// ---- testbench/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import rssc_pkg::*;
  // ****
  // Signals and tables
  // ****
  logic mclk;
  logic rst_n;
  logic clkEn;
  logic [7:0] regPage;
  logic [7:0] regCode;
  logic regWrite;
  logic regRead;
  logic [15:0] regWdata;
  logic [15:0] regRdata;
  logic regAck;
  logic regErr;
  logic [7:0] loadCurrent;
  rssc_shed_type shedState;
  logic railEnable;
  logic bootDone;
  logic decayMode;
  logic stepReq;
  logic refStep;
  logic bootActive;
  logic swCycle;
  logic [6:0] phaseLimitCode;
  logic [1:0][7:0] phaseCurrent;
  logic [1:0] valleyHit;
  int errorCnt = 0;
  int checked = 0;
  int cycles = 0;
  int n;
  logic [7:0] codes [4] = '{RSSC_CMD_SHED, RSSC_CMD_DECAY, RSSC_CMD_OFFSET, RSSC_CMD_SLEW};
  logic [15:0] masks [4] = '{RSSC_MASK_SHED, RSSC_MASK_DECAY, RSSC_MASK_OFFSET, RSSC_MASK_SLEW};
  logic [15:0] rsts [4] = '{RSSC_RST_SHED, RSSC_RST_DECAY, RSSC_RST_OFFSET, RSSC_RST_SLEW};
  // Load walk across thresholds and margins
  logic [7:0] loads [8] = '{8'h14, 8'h09, 8'h0C, 8'h0D, 8'h09, 8'h03, 8'h06, 8'h07};
  rssc_shed_type states [8] = '{RSSC_TWO_CCM, RSSC_ONE_CCM, RSSC_ONE_CCM, RSSC_TWO_CCM,
    RSSC_ONE_CCM, RSSC_ONE_DCM, RSSC_ONE_DCM, RSSC_ONE_CCM};
  // Device under test
  rssc_regs #(.NPHASE(2), .LOAD_W(8), .CUR_W(8)) dut (.mclk(mclk), .rst_n(rst_n),
    .clkEn(clkEn), .regPage(regPage), .regCode(regCode), .regWrite(regWrite),
    .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata), .regAck(regAck),
    .regErr(regErr), .loadCurrent(loadCurrent), .shedState(shedState),
    .railEnable(railEnable), .bootDone(bootDone), .decayMode(decayMode),
    .stepReq(stepReq), .refStep(refStep), .bootActive(bootActive), .swCycle(swCycle),
    .phaseLimitCode(phaseLimitCode), .phaseCurrent(phaseCurrent), .valleyHit(valleyHit));
  // Host model on the command port
  rssc_host host (.mclk(mclk), .regPage(regPage), .regCode(regCode),
    .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata),
    .regRdata(regRdata), .regAck(regAck), .regErr(regErr));
  // ****
  // Tasks
  // ****
  // Compare and count
  task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errorCnt++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  // Access; expected is {ack, err, data} in one word
  task automatic acc(input logic [7:0] page, input logic [7:0] code, input logic wr,
    input logic [15:0] wd, input logic [19:0] exp);
    logic [15:0] rd;
    logic [1:0] rsp;
    host.access(page, code, wr, wd, rd, rsp);
    chk({2'b00, rsp, rd}, exp);
  endtask
  // Cycles between two reference step pulses
  task automatic gap(output int cnt);
    cnt = 1;
    while (refStep !== 1'b1)
      @(negedge mclk);
    @(negedge mclk);
    while (refStep !== 1'b1)
    begin
      @(negedge mclk);
      cnt++;
    end
  endtask
  // Counts, verdict, end of run
  task automatic giveVerdict();
    $display("errors %0d checks %0d", errorCnt, checked);
    if (errorCnt == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Clock
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // Hang guard, well above the expected run length
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      errorCnt++;
      giveVerdict();
    end
  end
  // Main sequence
  initial
  begin
    rst_n = 1'b0;
    clkEn = 1'b1;
    loadCurrent = 8'h14;
    railEnable = 1'b0;
    bootDone = 1'b0;
    decayMode = 1'b0;
    stepReq = 1'b0;
    swCycle = 1'b0;
    phaseLimitCode = 7'h05;
    phaseCurrent = '0;
    repeat (5) @(negedge mclk);
    rst_n = 1'b1;
    // Reset value, all-ones write, masked readback
    for (int i = 0; i < 4; i++)
    begin
      acc(RSSC_PAGE_RAIL2, codes[i], 1'b0, 16'h0000, {4'h2, rsts[i]});
      acc(RSSC_PAGE_RAIL2, codes[i], 1'b1, 16'hFFFF, {4'h2, 16'h0000});
      acc(RSSC_PAGE_RAIL2, codes[i], 1'b0, 16'h0000, {4'h2, masks[i]});
    end
    // Wrong page and unmapped code are refused
    acc(8'h00, RSSC_CMD_SHED, 1'b0, 16'h0000, {4'h1, 16'h0000});
    acc(RSSC_PAGE_RAIL2, 8'hC8, 1'b0, 16'h0000, {4'h1, 16'h0000});
    // Shedding: margin 2, two-to-one below 10, discontinuous below 4
    acc(RSSC_PAGE_RAIL2, RSSC_CMD_SHED, 1'b1, 16'h08A4, {4'h2, 16'h0000});
    acc(8'h02, RSSC_CMD_SHED, 1'b1, 16'hFFFF, {4'h1, 16'h0000});
    acc(RSSC_PAGE_RAIL2, RSSC_CMD_SHED, 1'b0, 16'h0000, {4'h2, 16'h08A4});
    for (int i = 0; i < 8; i++)
    begin
      @(negedge mclk);
      loadCurrent = loads[i];
      repeat (3) @(negedge mclk);
      chk(20'(shedState), 20'(states[i]));
    end
    // Valley limit: reference is code 5 plus offset 10
    acc(RSSC_PAGE_RAIL2, RSSC_CMD_OFFSET, 1'b1, host.OFFSET_VAL, {4'h2, 16'h0000});
    for (int i = 0; i < 2; i++)
    begin
      phaseCurrent[i] = 8'h10;
      phaseCurrent[1-i] = 8'h0F;
      swCycle = 1'b1;
      @(negedge mclk);
      swCycle = 1'b0;
      @(negedge mclk);
      chk(20'(valleyHit), 20'(2'b01 << i));
    end
    // Decay hold of two counts under a standing request
    acc(RSSC_PAGE_RAIL2, RSSC_CMD_DECAY, 1'b1, 16'h0002, {4'h2, 16'h0000});
    // Enable low freezes the port: write not taken, no answer, data held
    @(negedge mclk);
    clkEn = 1'b0;
    acc(RSSC_PAGE_RAIL2, RSSC_CMD_DECAY, 1'b1, 16'h0001, {4'h0, 16'h0000});
    clkEn = 1'b1;
    acc(RSSC_PAGE_RAIL2, RSSC_CMD_DECAY, 1'b0, 16'h0000, {4'h2, 16'h0002});
    decayMode = 1'b1;
    stepReq = 1'b1;
    gap(n);
    chk(20'(n >= 2 * RSSC_DECAY_LSB_CYC && n <= 42), 20'h00001);
    stepReq = 1'b0;
    decayMode = 1'b0;
    // Turn-on ramp paced at (2+3) step units
    acc(RSSC_PAGE_RAIL2, RSSC_CMD_SLEW, 1'b1, 16'h0002, {4'h2, 16'h0000});
    chk(20'(bootActive), 20'h00000);
    railEnable = 1'b1;
    @(negedge mclk);
    @(negedge mclk);
    chk(20'(bootActive), 20'h00001);
    gap(n);
    chk(20'(n), 20'(5 * RSSC_BOOT_LSB_CYC));
    // Count with low five bits set is kept but has no effect
    acc(RSSC_PAGE_RAIL2, RSSC_CMD_SLEW, 1'b1, 16'h001F, {4'h2, 16'h0000});
    acc(RSSC_PAGE_RAIL2, RSSC_CMD_SLEW, 1'b0, 16'h0000, {4'h2, 16'h001F});
    gap(n);
    chk(20'(n), 20'(5 * RSSC_BOOT_LSB_CYC));
    // After the ramp, steps follow requests directly
    bootDone = 1'b1;
    @(negedge mclk);
    @(negedge mclk);
    chk(20'(bootActive), 20'h00000);
    stepReq = 1'b1;
    @(negedge mclk);
    stepReq = 1'b0;
    chk(20'(refStep), 20'h00001);
    @(negedge mclk);
    chk(20'(refStep), 20'h00000);
    giveVerdict();
  end
endmodule
`default_nettype wire
